// *** hdl/taxt_pkg.sv ***
// shared constants, state encoding and decode helpers for the table, test and xor unit
package taxt_pkg;

  // ----------------------------------------------------------------
  // widths and reset values
  // ----------------------------------------------------------------
  localparam int PTR_W = 21;
  localparam int HOLD_N = 8;
  localparam logic [20:0] PTR_RST = 21'h000000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] HOLD_RST = 8'hff;
  localparam logic [3:0] BANK_RST = 4'h0;
  localparam logic [1:0] PHASE_Q1 = 2'h0;
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;

  // ----------------------------------------------------------------
  // register offsets (byte addresses) and status fields
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PTR = 8'h00;
  localparam logic [7:0] OFS_LATCH = 8'h04;
  localparam logic [7:0] OFS_ACC = 8'h08;
  localparam logic [7:0] OFS_BANK = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_HOLD = 8'h20;
  localparam logic [7:0] HOLD_MASK = 8'he3;
  localparam int ST_NEG_BIT = 0;
  localparam int ST_ZERO_BIT = 1;
  localparam int ST_BUSY_BIT = 2;

  // ----------------------------------------------------------------
  // access bank split and pointer update modes
  // ----------------------------------------------------------------
  localparam logic [7:0] ACC_SPLIT = 8'h80;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [3:0] ACC_HI_BANK = 4'hf;
  localparam logic [1:0] MODE_KEEP = 2'h0;
  localparam logic [1:0] MODE_POST_INC = 2'h1;
  localparam logic [1:0] MODE_POST_DEC = 2'h2;
  localparam logic [1:0] MODE_PRE_INC = 2'h3;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_TBL2 = 4'b0100,
    ST_SKIP = 4'b1000
  } taxt_state_t;

  // ----------------------------------------------------------------
  // opcode decode
  // ----------------------------------------------------------------
  function automatic logic is_table_read_op(input logic [15:0] i);
    return i[15:2] == 14'h0002;
  endfunction : is_table_read_op

  function automatic logic is_table_write_op(input logic [15:0] i);
    return i[15:2] == 14'h0003;
  endfunction : is_table_write_op

  function automatic logic is_tst(input logic [15:0] i);
    return i[15:9] == 7'h33;
  endfunction : is_tst

  function automatic logic is_xor_literal(input logic [15:0] i);
    return i[15:8] == 8'h0a;
  endfunction : is_xor_literal

  function automatic logic is_xor_file(input logic [15:0] i);
    return i[15:10] == 6'h06;
  endfunction : is_xor_file

  // ----------------------------------------------------------------
  // address and pointer arithmetic
  // ----------------------------------------------------------------
  function automatic logic [11:0] file_addr(input logic a, input logic [7:0] f,
                                            input logic [3:0] bank);
    if (a) begin
      return {bank, f};
    end
    return (f < ACC_SPLIT) ? {ACC_LO_BANK, f} : {ACC_HI_BANK, f};
  endfunction : file_addr

  function automatic logic [20:0] ptr_pre(input logic [20:0] p, input logic [1:0] m);
    return (m == MODE_PRE_INC) ? 21'(p + 21'h000001) : p;
  endfunction : ptr_pre

  function automatic logic [20:0] ptr_post(input logic [20:0] p, input logic [1:0] m);
    case (m)
      MODE_POST_INC: return 21'(p + 21'h000001);
      MODE_POST_DEC: return 21'(p - 21'h000001);
      default: return p;
    endcase
  endfunction : ptr_post

  function automatic logic [7:0] byte_sel(input logic hi, input logic [15:0] w);
    return hi ? w[15:8] : w[7:0];
  endfunction : byte_sel

endpackage : taxt_pkg

// *** hdl/taxt_hold_if.sv ***
// carrier between the sequencer and the write holding buffer
`timescale 1ns/10ps
interface taxt_hold_if;
  logic we;
  logic [2:0] widx;
  logic [7:0] wdata;
  logic [2:0] ridx;
  logic [7:0] rdata;

  modport seq (output we, output widx, output wdata, output ridx, input rdata);
  modport buffer (input we, input widx, input wdata, input ridx, output rdata);
endinterface : taxt_hold_if

// *** hdl/taxt_hold_buf.sv ***
// eight byte holding buffer that stages data for later programming
`timescale 1ns/10ps
module taxt_hold_buf (
  // clock, reset and enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // sequencer side
  taxt_hold_if.buffer hb
);

  typedef struct packed {
    logic [7:0][7:0] bytes;
  } taxt_hold_st_t;

  taxt_hold_st_t s_q;
  taxt_hold_st_t s_d;

  // ----------------------------------------------------------------
  // write port
  // ----------------------------------------------------------------
  // one byte per write, selected by the low pointer bits
  always_comb begin
    s_d = s_q;
    if (hb.we) begin
      s_d.bytes[hb.widx] = hb.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= {8{taxt_pkg::HOLD_RST}};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // read port is a plain mux so software can inspect staged data
  assign hb.rdata = s_q.bytes[hb.ridx];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_hold_store;
    @(posedge clk) disable iff (!rst_n || !ce)
    hb.we |=> s_q.bytes[$past(hb.widx)] == $past(hb.wdata);
  endproperty
  a_hold_store: assert property (p_hold_store) else $error("holding byte not stored");

endmodule : taxt_hold_buf

// *** hdl/taxt_core.sv ***
// table access, test-and-skip and xor execution unit with apb register access
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/10ps
// What this block does
// - the table pointer is 21 bits wide and addresses single bytes over 2 Mbyte.
// - pointer bit 0 picks the low byte of a program word when 0 and the high byte when 1.
// - a table read, opcode 0000 0000 0000 10 plus two mode bits, copies the byte to the latch.
// - the mode field keeps, post-increments, post-decrements or pre-increments the pointer.
// - a table read takes two cycles, reads memory in Q2 and writes the latch in Q4 of cycle 2.
// - a table write copies the latch into the holding byte picked by the low three pointer bits.
// - table writes only fill the holding bytes and never touch program memory directly.
// - a table write uses opcode low nibble 11 plus the same four pointer update modes.
// - test-and-skip reads the file register and, if it is zero, turns the next fetch into a nop.
// - test-and-skip takes one cycle, two on a skip, three over a two-word op, flags untouched.
// - test-and-skip is encoded 0110 011a followed by the 8-bit file address.
// - access bit 0 uses the access bank and ignores the bank register, 1 uses the bank register.
// - xor with literal updates the accumulator in one cycle and sets only negative and zero.
// - xor with file sets negative and zero and stores to the accumulator (d=0) or the file (d=1).
module taxt_core (
  // clock, reset and enable
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic CE,
  // instruction issue
  input wire logic [15:0] INSTR,
  input wire logic INSTR_VALID,
  input wire logic NEXT_TWO_WORD,
  output logic BUSY,
  output logic SKIP_DISCARD,
  // program memory read port
  output logic [19:0] PM_ADDR,
  output logic PM_RD,
  input wire logic [15:0] PM_RDATA,
  // file register port
  output logic [11:0] FILE_ADDR,
  input wire logic [7:0] FILE_RDATA,
  output logic FILE_WE,
  output logic [7:0] FILE_WDATA,
  output logic [7:0] ACC,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);

  typedef struct packed {
    taxt_pkg::taxt_state_t state;
    logic [1:0] phase;
    logic [15:0] instr;
    logic [20:0] ptr;
    logic [7:0] latch;
    logic [7:0] acc;
    logic [3:0] bank;
    logic neg;
    logic zero;
    logic [7:0] data;
    logic [15:0] word;
    logic [1:0] skip_cnt;
    logic two_word;
    logic busy;
    logic discard;
    logic [19:0] pm_addr;
    logic pm_rd;
    logic [11:0] file_addr;
    logic file_we;
    logic [7:0] file_wdata;
    logic hold_we;
    logic [2:0] hold_idx;
    logic [7:0] hold_data;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } taxt_core_st_t;

  taxt_core_st_t s_q;
  taxt_core_st_t s_d;
  taxt_hold_if hb ();

  logic accept;
  logic apb_wr;
  logic [7:0] res;

  // ----------------------------------------------------------------
  // holding buffer
  // ----------------------------------------------------------------
  taxt_hold_buf u_hold (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .ce(CE),
    .hb(hb)
  );

  // staged bytes go only to the buffer; no program memory write path exists
  assign hb.we = s_q.hold_we;
  assign hb.widx = s_q.hold_idx;
  assign hb.wdata = s_q.hold_data;
  assign hb.ridx = PADDR[4:2];

  assign accept = (s_q.state == taxt_pkg::ST_IDLE) && INSTR_VALID;
  assign apb_wr = PSEL && PENABLE && PWRITE && s_q.pready;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // apb is handled first so a core update in the same cycle wins
  always_comb begin
    s_d = s_q;
    res = 8'h00;
    s_d.pm_rd = 1'b0;
    s_d.file_we = 1'b0;
    s_d.hold_we = 1'b0;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    // one wait state: answer is registered in the first access cycle
    if (PSEL && PENABLE && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h00000000;
      case (PADDR)
        taxt_pkg::OFS_PTR: s_d.prdata = {11'h000, s_q.ptr};
        taxt_pkg::OFS_LATCH: s_d.prdata = {24'h000000, s_q.latch};
        taxt_pkg::OFS_ACC: s_d.prdata = {24'h000000, s_q.acc};
        taxt_pkg::OFS_BANK: s_d.prdata = {28'h0000000, s_q.bank};
        taxt_pkg::OFS_STATUS: s_d.prdata = {29'h00000000, s_q.busy, s_q.zero, s_q.neg};
        default: begin
          if ((PADDR & taxt_pkg::HOLD_MASK) == taxt_pkg::OFS_HOLD) begin
            if (!PWRITE) begin
              s_d.prdata = {24'h000000, hb.rdata};
            end else begin
              s_d.pslverr = 1'b1; // holding bytes are read only
            end
          end else begin
            s_d.pslverr = 1'b1;
          end
        end
      endcase
    end
    // writes take effect on the completing edge only
    if (apb_wr) begin
      case (PADDR)
        taxt_pkg::OFS_PTR: s_d.ptr = PWDATA[20:0];
        taxt_pkg::OFS_LATCH: s_d.latch = PWDATA[7:0];
        taxt_pkg::OFS_ACC: s_d.acc = PWDATA[7:0];
        taxt_pkg::OFS_BANK: s_d.bank = PWDATA[3:0];
        taxt_pkg::OFS_STATUS: begin
          s_d.neg = PWDATA[taxt_pkg::ST_NEG_BIT];
          s_d.zero = PWDATA[taxt_pkg::ST_ZERO_BIT];
        end
        default: s_d.ptr = s_d.ptr;
      endcase
    end
    // phase counter runs Q1..Q4 while an instruction is in flight
    if (s_q.state != taxt_pkg::ST_IDLE) begin
      s_d.phase = 2'(s_q.phase + 2'h1);
    end
    case (s_q.state)
      taxt_pkg::ST_IDLE: begin
        if (accept) begin
          s_d.instr = INSTR;
          s_d.state = taxt_pkg::ST_EXEC;
          s_d.phase = taxt_pkg::PHASE_Q1;
          s_d.busy = 1'b1;
          s_d.two_word = NEXT_TWO_WORD;
          s_d.file_addr = taxt_pkg::file_addr(INSTR[8], INSTR[7:0], s_q.bank);
        end
      end
      taxt_pkg::ST_EXEC: begin
        if (s_q.phase == taxt_pkg::PHASE_Q2) begin
          s_d.data = FILE_RDATA;
        end
        if (s_q.phase == taxt_pkg::PHASE_Q4) begin
          s_d.state = taxt_pkg::ST_IDLE;
          s_d.busy = 1'b0;
          if (taxt_pkg::is_xor_literal(s_q.instr)) begin
            res = s_q.acc ^ s_q.instr[7:0];
            s_d.acc = res;
            s_d.neg = res[7];
            s_d.zero = (res == 8'h00);
          end else if (taxt_pkg::is_xor_file(s_q.instr)) begin
            res = s_q.acc ^ s_q.data;
            s_d.neg = res[7];
            s_d.zero = (res == 8'h00);
            if (s_q.instr[9]) begin
              s_d.file_we = 1'b1;
              s_d.file_wdata = res;
            end else begin
              s_d.acc = res;
            end
          end else if (taxt_pkg::is_tst(s_q.instr)) begin
            // flags are deliberately left alone here
            if (s_q.data == 8'h00) begin
              s_d.state = taxt_pkg::ST_SKIP;
              s_d.busy = 1'b1;
              s_d.discard = 1'b1;
              s_d.skip_cnt = s_q.two_word ? 2'h2 : 2'h1;
            end
          end else if (taxt_pkg::is_table_read_op(s_q.instr)
                       || taxt_pkg::is_table_write_op(s_q.instr)) begin
            // pre-increment lands before cycle 2 so read and holding index see it
            s_d.ptr = taxt_pkg::ptr_pre(s_q.ptr, s_q.instr[1:0]);
            s_d.state = taxt_pkg::ST_TBL2;
            s_d.busy = 1'b1;
          end
        end
      end
      taxt_pkg::ST_TBL2: begin
        if (s_q.phase == taxt_pkg::PHASE_Q1 && taxt_pkg::is_table_read_op(s_q.instr)) begin
          s_d.pm_rd = 1'b1;
          s_d.pm_addr = s_q.ptr[20:1];
        end
        if (s_q.pm_rd) begin
          s_d.word = PM_RDATA;
        end
        if (s_q.phase == taxt_pkg::PHASE_Q4) begin
          if (taxt_pkg::is_table_read_op(s_q.instr)) begin
            s_d.latch = taxt_pkg::byte_sel(s_q.ptr[0], s_q.word);
          end else begin
            s_d.hold_we = 1'b1;
            s_d.hold_idx = s_q.ptr[2:0];
            s_d.hold_data = s_q.latch;
          end
          s_d.ptr = taxt_pkg::ptr_post(s_q.ptr, s_q.instr[1:0]);
          s_d.state = taxt_pkg::ST_IDLE;
          s_d.busy = 1'b0;
        end
      end
      taxt_pkg::ST_SKIP: begin
        // one nop cycle per discarded word
        if (s_q.phase == taxt_pkg::PHASE_Q4) begin
          s_d.skip_cnt = 2'(s_q.skip_cnt - 2'h1);
          if (s_q.skip_cnt == 2'h1) begin
            s_d.state = taxt_pkg::ST_IDLE;
            s_d.busy = 1'b0;
            s_d.discard = 1'b0;
          end
        end
      end
      default: begin
        s_d.state = taxt_pkg::ST_IDLE;
        s_d.busy = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // the enable freezes everything, bus handshake included
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_q <= '0;
      s_q.state <= taxt_pkg::ST_IDLE;
      s_q.ptr <= taxt_pkg::PTR_RST;
      s_q.latch <= taxt_pkg::BYTE_RST;
      s_q.acc <= taxt_pkg::BYTE_RST;
      s_q.bank <= taxt_pkg::BANK_RST;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  // outputs are taken straight from the state register
  assign BUSY = s_q.busy;
  assign SKIP_DISCARD = s_q.discard;
  assign PM_ADDR = s_q.pm_addr;
  assign PM_RD = s_q.pm_rd;
  assign FILE_ADDR = s_q.file_addr;
  assign FILE_WE = s_q.file_we;
  assign FILE_WDATA = s_q.file_wdata;
  assign ACC = s_q.acc;
  assign PRDATA = s_q.prdata;
  assign PREADY = s_q.pready;
  assign PSLVERR = s_q.pslverr;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN || !CE);

  property p_rd_addr;
    PM_RD |-> PM_ADDR == s_q.ptr[20:1];
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("read address off pointer");

  property p_byte_sel;
    (s_q.state == taxt_pkg::ST_TBL2) && (s_q.phase == taxt_pkg::PHASE_Q4)
      && taxt_pkg::is_table_read_op(s_q.instr) && !apb_wr
      |=> s_q.latch == ($past(s_q.ptr[0]) ? $past(s_q.word[15:8]) : $past(s_q.word[7:0]));
  endproperty
  a_byte_sel: assert property (p_byte_sel) else $error("wrong byte of program word");

  property p_rd_timing;
    accept && taxt_pkg::is_table_read_op(INSTR) |-> ##6 PM_RD ##1 !PM_RD ##2 !BUSY;
  endproperty
  a_rd_timing: assert property (p_rd_timing) else $error("table read timing off");

  property p_post_inc;
    (s_q.state == taxt_pkg::ST_TBL2) && (s_q.phase == taxt_pkg::PHASE_Q4)
      && (s_q.instr[1:0] == taxt_pkg::MODE_POST_INC) && !apb_wr
      |=> s_q.ptr == 21'($past(s_q.ptr) + 21'h000001);
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("post increment missing");

  property p_hold_idx;
    s_q.hold_we |-> s_q.hold_idx == $past(s_q.ptr[2:0]) && s_q.hold_data == $past(s_q.latch);
  endproperty
  a_hold_idx: assert property (p_hold_idx) else $error("holding index or data wrong");

  property p_skip_len;
    $rose(SKIP_DISCARD) && !s_q.two_word |-> SKIP_DISCARD[*4] ##1 !SKIP_DISCARD;
  endproperty
  a_skip_len: assert property (p_skip_len) else $error("skip not one cycle");

  property p_skip_cause;
    $rose(SKIP_DISCARD) |-> taxt_pkg::is_tst(s_q.instr) && $past(s_q.data) == 8'h00;
  endproperty
  a_skip_cause: assert property (p_skip_cause) else $error("skip without zero test");

  property p_bank_sel;
    accept && !INSTR[8] |=> FILE_ADDR == {($past(INSTR[7]) ? taxt_pkg::ACC_HI_BANK
      : taxt_pkg::ACC_LO_BANK), $past(INSTR[7:0])};
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("access bank not used");

  property p_xor_literal;
    accept && taxt_pkg::is_xor_literal(INSTR) |-> ##4 !apb_wr ##1
      ACC == ($past(ACC, 5) ^ $past(INSTR[7:0], 5)) && !BUSY;
  endproperty
  a_xor_literal: assert property (p_xor_literal) else $error("literal xor result wrong");

  property p_xor_file;
    FILE_WE |-> FILE_WDATA == (s_q.acc ^ s_q.data) && s_q.instr[9];
  endproperty
  a_xor_file: assert property (p_xor_file) else $error("file xor write wrong");

  c_table_read: cover property (accept && taxt_pkg::is_table_read_op(INSTR) ##9 !BUSY);
  c_table_write: cover property (s_q.hold_we);
  c_skip2: cover property ($rose(SKIP_DISCARD) && s_q.two_word);

endmodule : taxt_core

// *** tb/taxt_mem_model.sv ***
// program memory and file register model facing the execution unit
`timescale 1ns/10ps
module taxt_mem_model (
  // clock
  input wire logic clk,
  // program memory read port
  input wire logic [19:0] pm_addr,
  input wire logic pm_rd,
  output logic [15:0] pm_rdata,
  // file register port
  input wire logic [11:0] file_addr,
  output logic [7:0] file_rdata,
  input wire logic file_we,
  input wire logic [7:0] file_wdata
);
  logic [7:0] fmem [4096];
  logic [15:0] last_q = 16'h0000;

  function automatic logic [15:0] pm_word(input logic [19:0] a);
    return {a[7:0] ^ 8'ha5, a[7:0]};
  endfunction : pm_word

  // read-only store: no write path, so table writes cannot reach it
  assign pm_rdata = pm_rd ? pm_word(pm_addr) : ~last_q;
  // outside a strobe the bus shows the inverse of the last word, never a stale copy
  always @(posedge clk) begin
    if (pm_rd) begin
      last_q <= pm_word(pm_addr);
    end
  end

  // file registers, read at any time, written on the strobe
  assign file_rdata = fmem[file_addr];
  always @(posedge clk) begin
    if (file_we) begin
      fmem[file_addr] <= file_wdata;
    end
  end

  // nonzero fill so that only chosen cells test as zero
  initial begin
    foreach (fmem[i]) begin
      fmem[i] = 8'h01;
    end
  end
endmodule : taxt_mem_model

// *** tb/tb.sv ***
// self-checking bench for the table, test and xor unit
`timescale 1ns/10ps
module tb;
  logic ref_clk, rstn, instr_valid, next_two, psel, penable, pwrite, err, skp;
  logic ce;
  logic busy, skip_discard, pm_rd, file_we, pready, pslverr;
  logic [15:0] instr, pm_rdata;
  logic [19:0] pm_addr;
  logic [11:0] file_addr;
  logic [7:0] paddr, file_rdata, file_wdata, acc;
  logic [31:0] pwdata, prdata, rd;
  logic [20:0] p, ea;
  logic [20:0] ptab [4] = '{21'h00a356, 21'h1fffff, 21'h01389a, 21'h01a357};
  logic [15:0] ti [3] = '{16'h6690, 16'h6790, 16'h6690};
  int tc [3] = '{8, 4, 12};
  int error_cnt = 0;
  int checks_done = 0;
  int cyc;

  taxt_core i_dut (.REF_CLK(ref_clk), .RSTN(rstn), .CE(ce), .INSTR(instr),
    .INSTR_VALID(instr_valid), .NEXT_TWO_WORD(next_two), .BUSY(busy),
    .SKIP_DISCARD(skip_discard), .PM_ADDR(pm_addr), .PM_RD(pm_rd), .PM_RDATA(pm_rdata),
    .FILE_ADDR(file_addr), .FILE_RDATA(file_rdata), .FILE_WE(file_we),
    .FILE_WDATA(file_wdata), .ACC(acc), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));

  taxt_mem_model i_mem (.clk(ref_clk), .pm_addr(pm_addr), .pm_rd(pm_rd),
    .pm_rdata(pm_rdata), .file_addr(file_addr), .file_rdata(file_rdata),
    .file_we(file_we), .file_wdata(file_wdata));

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    int n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      chk("apb timeout", 32'h1, 32'h0);
      stop_test();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, err);
    chk($sformatf("reg %h", a), rd, exp);
  endtask : rdchk

  // issue one instruction, count cycles until busy drops, note any discard
  task automatic exec(input logic [15:0] i, input logic tw, output int c, output logic s);
    @(posedge ref_clk);
    instr <= i;
    next_two <= tw;
    instr_valid <= 1'b1;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    c = 0;
    s = 1'b0;
    do begin
      @(posedge ref_clk);
      #1;
      c++;
      s = s | (skip_discard === 1'b1);
    end while (busy !== 1'b0 && c < 40);
    // a hang counts as a mismatch and ends the run
    if (c >= 40) begin
      chk("busy timeout", 32'h1, 32'h0);
      stop_test();
    end
  endtask : exec

  // byte the memory model holds at a byte address
  function automatic logic [7:0] byte_of(input logic [20:0] a);
    logic [15:0] w;
    w = {a[8:1] ^ 8'ha5, a[8:1]};
    return a[0] ? w[15:8] : w[7:0];
  endfunction : byte_of

  function automatic logic [20:0] np(input logic [20:0] q, input int m);
    return (m == 2) ? 21'(q - 21'h1) : ((m == 0) ? q : 21'(q + 21'h1));
  endfunction : np

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {instr_valid, next_two, psel, penable, pwrite} = 5'h00;
    ce = 1'b1;
    instr = 16'h0000;
    paddr = 8'h00;
    pwdata = 32'h0;
    rstn = 1'b0;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    rdchk(taxt_pkg::OFS_PTR, 32'h0);
    rdchk(taxt_pkg::OFS_HOLD, 32'hff);
    apb(1'b0, 8'h14, 32'h0, rd, err);
    chk("unmapped slverr", 32'(err), 32'h1);
    apb(1'b1, taxt_pkg::OFS_HOLD, 32'h12, rd, err);
    chk("hold write slverr", 32'(err), 32'h1);
    $display("test reset and refusals done");
    // table reads in every mode, wrap included
    for (int m = 0; m < 4; m++) begin
      p = ptab[m];
      wr(taxt_pkg::OFS_PTR, 32'(p));
      exec({14'h0002, 2'(m)}, 1'b0, cyc, skp);
      ea = (m == 3) ? 21'(p + 21'h1) : p;
      chk("read cycles", cyc, 8);
      rdchk(taxt_pkg::OFS_LATCH, 32'(byte_of(ea)));
      rdchk(taxt_pkg::OFS_PTR, 32'(np(p, m)));
    end
    $display("test table read done");
    // table writes in every mode, each to its own holding byte
    for (int m = 0; m < 4; m++) begin
      p = ptab[m];
      wr(taxt_pkg::OFS_LATCH, 32'h40 + m);
      wr(taxt_pkg::OFS_PTR, 32'(p));
      exec({14'h0003, 2'(m)}, 1'b0, cyc, skp);
      ea = (m == 3) ? 21'(p + 21'h1) : p;
      chk("write cycles", cyc, 8);
      rdchk(8'h20 + {3'h0, ea[2:0], 2'h0}, 32'h40 + m);
      rdchk(taxt_pkg::OFS_PTR, 32'(np(p, m)));
    end
    $display("test table write done");
    // test and skip: access bank zero, banked nonzero, skip over a two-word op
    wr(taxt_pkg::OFS_BANK, 32'h5);
    wr(taxt_pkg::OFS_STATUS, 32'h3);
    i_mem.fmem[12'hf90] = 8'h00;
    i_mem.fmem[12'h590] = 8'h07;
    for (int k = 0; k < 3; k++) begin
      exec(ti[k], k == 2, cyc, skp);
      chk("skip cycles", cyc, tc[k]);
      chk("discard seen", 32'(skp), 32'(k != 1));
    end
    rdchk(taxt_pkg::OFS_STATUS, 32'h3);
    $display("test skip done");
    // xor with literal, then to zero
    wr(taxt_pkg::OFS_ACC, 32'hb5);
    exec(16'h0aaf, 1'b0, cyc, skp);
    chk("xorl cycles", cyc, 4);
    chk("acc", 32'(acc), 32'h1a);
    rdchk(taxt_pkg::OFS_STATUS, 32'h0);
    exec(16'h0a1a, 1'b0, cyc, skp);
    rdchk(taxt_pkg::OFS_STATUS, 32'h2);
    // xor with file to the file, then to the accumulator
    i_mem.fmem[12'h020] = 8'haf;
    wr(taxt_pkg::OFS_ACC, 32'hb5);
    exec(16'h1a20, 1'b0, cyc, skp);
    // the file cell is written one edge after busy drops, so look after the bus read
    rdchk(taxt_pkg::OFS_ACC, 32'hb5);
    chk("file result", 32'(i_mem.fmem[12'h020]), 32'h1a);
    exec(16'h1820, 1'b0, cyc, skp);
    chk("acc result", 32'(acc), 32'haf);
    rdchk(taxt_pkg::OFS_STATUS, 32'h1);
    $display("test xor done");
    // enable low: an offered instruction is not taken and nothing moves
    @(posedge ref_clk);
    ce <= 1'b0;
    exec(16'h0aff, 1'b0, cyc, skp);
    chk("frozen cycles", cyc, 1);
    chk("frozen acc", 32'(acc), 32'haf);
    @(posedge ref_clk);
    ce <= 1'b1;
    exec(16'h0aff, 1'b0, cyc, skp);
    chk("resumed cycles", cyc, 4);
    chk("resumed acc", 32'(acc), 32'h50);
    $display("test enable done");
    stop_test();
  end
endmodule : tb
